// >>> logic/bst_pkg.sv
// boundary-scan tap constants, instruction codes and controller states
package bst_pkg;

  // instruction register
  localparam int IR_W = 4;
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_SAMPLE = 4'h1;
  localparam logic [3:0] INS_IDCODE = 4'h2;
  localparam logic [3:0] INS_CLAMP = 4'h3;
  localparam logic [3:0] INS_HIGHZ = 4'h4;
  localparam logic [3:0] INS_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET = INS_IDCODE;

  // identification register layout
  localparam int ID_W = 32;
  localparam int ID_REV_LSB = 28;
  localparam int ID_REV_W = 4;
  localparam int ID_PART_LSB = 12;
  localparam int ID_PART_W = 16;
  localparam int ID_MFR_LSB = 1;
  localparam int ID_MFR_W = 11;
  localparam logic ID_MARK = 1'b1;

  // bypass stage captures zero
  localparam logic BYP_CAPTURE = 1'b0;

  // test clock rate and core-side synchroniser depth
  localparam int TCK_FREQ_MHZ = 10;
  localparam int TCK_PERIOD_NS = 1000 / TCK_FREQ_MHZ;
  localparam int SYNC_STAGES = 2;

  // serial path selected for data-register scans
  typedef enum logic [1:0] {
    PATH_BYP = 2'h0,
    PATH_ID = 2'h1,
    PATH_BSR = 2'h3
  } bst_path_t;

  // tap controller states, gray along the usual walk
  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SHIFT_DR = 4'h6,
    ST_EXIT1_DR = 4'h7,
    ST_PAUSE_DR = 4'h5,
    ST_EXIT2_DR = 4'h4,
    ST_UPD_DR = 4'hc,
    ST_SEL_IR = 4'hd,
    ST_CAP_IR = 4'hf,
    ST_SHIFT_IR = 4'he,
    ST_EXIT1_IR = 4'ha,
    ST_PAUSE_IR = 4'hb,
    ST_EXIT2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } bst_state_t;

endpackage

// >>> logic/bst_tap_fsm.sv
// sixteen-state test controller, clocked by the test clock
`timescale 1ns/100ps
`default_nettype none
module bst_tap_fsm (
  input wire logic i_tck,
  input wire logic i_tap_rst_n,
  input wire logic i_tms,
  output bst_pkg::bst_state_t o_state
);
  import bst_pkg::*;

  bst_state_t state_reg;
  bst_state_t state_next;

  // tms steers every transition
  always_comb begin
    case (state_reg)
      ST_TLR: state_next = i_tms ? ST_TLR : ST_RTI;
      ST_RTI: state_next = i_tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_next = i_tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_next = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_next = i_tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_next = i_tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_next = i_tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_next = i_tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_next = i_tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_next = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_next = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_next = i_tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_next = i_tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_next = i_tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_next = i_tms ? ST_SEL_DR : ST_RTI;
      default: state_next = ST_TLR;
    endcase
  end

  // tms sampled on the rising test clock edge
  always_ff @(posedge i_tck or negedge i_tap_rst_n) begin
    if (!i_tap_rst_n) begin
      state_reg <= ST_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_state = state_reg;

endmodule
`default_nettype wire

// >>> logic/bst_cell_chain.sv
// boundary cell chain: input cells, then data and enable per output
`timescale 1ns/100ps
`default_nettype none
module bst_cell_chain #(
  parameter int N_IN = 8,
  parameter int N_OUT = 4
) (
  input wire logic i_tck,
  input wire logic i_tap_rst_n,
  input wire logic i_capture,
  input wire logic i_shift,
  input wire logic i_update,
  input wire logic i_tdi,
  input wire logic [N_IN-1:0] i_pin_in,
  input wire logic [N_OUT-1:0] i_pin_out,
  input wire logic [N_OUT-1:0] i_pin_oe,
  output logic o_so,
  output logic [N_OUT-1:0] o_upd_out,
  output logic [N_OUT-1:0] o_upd_oe
);
  import bst_pkg::*;

  localparam int LEN = N_IN + 2 * N_OUT;

  logic [LEN-1:0] chain_reg;
  logic [LEN-1:0] capture_vec;

  // inputs low, then each output as data followed by its enable
  always_comb begin
    capture_vec = '0;
    capture_vec[N_IN-1:0] = i_pin_in;
    for (int j = 0; j < N_OUT; j++) begin
      capture_vec[N_IN + 2 * j] = i_pin_out[j];
      capture_vec[N_IN + 2 * j + 1] = i_pin_oe[j];
    end
  end

  // shift toward bit 0 so bit 0 leaves first
  always_ff @(posedge i_tck or negedge i_tap_rst_n) begin
    if (!i_tap_rst_n) begin
      chain_reg <= '0;
    end else if (i_capture) begin
      chain_reg <= capture_vec;
    end else if (i_shift) begin
      chain_reg <= {i_tdi, chain_reg[LEN-1:1]};
    end
  end

  // update stage holds values until the next update-dr
  always_ff @(posedge i_tck or negedge i_tap_rst_n) begin
    if (!i_tap_rst_n) begin
      o_upd_out <= '0;
      o_upd_oe <= '0;
    end else if (i_update) begin
      for (int j = 0; j < N_OUT; j++) begin
        o_upd_out[j] <= chain_reg[N_IN + 2 * j];
        o_upd_oe[j] <= chain_reg[N_IN + 2 * j + 1];
      end
    end
  end

  assign o_so = chain_reg[0];

endmodule
`default_nettype wire

// >>> logic/bst_tap.sv
// boundary-scan tap top: instruction, bypass, id, pin muxing, tdo
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - 4-bit instruction register shifts in shift-ir
// - instruction picks data register and serial path
// - one-bit bypass stage from tdi to tdo
// - boundary chain bit 0 shifts out first
// - enable cells drive their pins when one
// - id holds revision, part, maker fields
// - id bit 0 always reads one
// - extest drives cells, boundary chain scanned
// - bypass code scans only bypass stage
// - idcode loads and scans identification register
// - highz floats outputs, scans bypass stage
// - clamp drives cells, scans bypass stage
// - sample captures pin inputs and outputs
// - preload shifts cells without disturbing pins
// - test pins kept out of chain
// - sample on rising tck, tdo on falling
// - tdo floats unless shifting
// - test reset resets scan; core drives pins again
module bst_tap #(
  parameter int N_IN = 8,
  parameter int N_OUT = 4,
  parameter logic [3:0] ID_REV = 4'h1, // arbitrary value
  parameter logic [15:0] ID_PART = 16'h5a5a, // arbitrary value
  parameter logic [10:0] ID_MFR = 11'h2c6 // arbitrary value
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  output logic o_tdo,
  output logic o_tdo_oe,
  input wire logic [N_IN-1:0] i_pin_in,
  input wire logic [N_OUT-1:0] i_core_out,
  input wire logic [N_OUT-1:0] i_core_oe,
  output logic [N_OUT-1:0] o_pin_out,
  output logic [N_OUT-1:0] o_pin_oe,
  output logic o_core_test_active
);
  import bst_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // decode helpers

  // data-register path for an instruction; reserved codes fall to bypass
  function automatic bst_path_t path_of(input logic [IR_W-1:0] ins);
    case (ins)
      INS_EXTEST: path_of = PATH_BSR;
      INS_SAMPLE: path_of = PATH_BSR;
      INS_IDCODE: path_of = PATH_ID;
      INS_CLAMP: path_of = PATH_BYP;
      INS_HIGHZ: path_of = PATH_BYP;
      INS_BYPASS: path_of = PATH_BYP;
      default: path_of = PATH_BYP;
    endcase
  endfunction

  // instructions that hand the output pins to the update stage
  function automatic logic forces_pins(input logic [IR_W-1:0] ins);
    forces_pins = (ins == INS_EXTEST) || (ins == INS_CLAMP);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // signals

  localparam logic [ID_W-1:0] ID_VALUE = {ID_REV, ID_PART, ID_MFR, ID_MARK};

  logic tap_rst_n;
  bst_state_t state;
  bst_path_t path;
  logic [IR_W-1:0] ir_shift_reg;
  logic [IR_W-1:0] instr_reg;
  logic [ID_W-1:0] id_shift_reg;
  logic bypass_reg;
  logic bsr_so;
  logic serial_bit;
  logic shifting;
  logic [N_OUT-1:0] upd_out;
  logic [N_OUT-1:0] upd_oe;
  logic test_active_reg;
  logic [SYNC_STAGES-1:0] core_sync_reg;
  localparam int OBS_W = N_IN + 2 * N_OUT;
  logic [OBS_W-1:0] obs_meta_reg;
  logic [OBS_W-1:0] obs_sync_reg;

  // either reset pin clears the scan logic
  assign tap_rst_n = i_rst_n & i_trst_n;
  assign path = path_of(instr_reg);
  assign shifting = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);

  ////////////////////////////////////////////////////////////////////
  // controller

  bst_tap_fsm u_fsm (
    .i_tck(i_tck),
    .i_tap_rst_n(tap_rst_n),
    .i_tms(i_tms),
    .o_state(state)
  );

  ////////////////////////////////////////////////////////////////////
  // instruction register

  // fixed 01 capture pattern, then serial shift from tdi
  always_ff @(posedge i_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_shift_reg <= IR_CAPTURE;
    end else if (state == ST_CAP_IR) begin
      ir_shift_reg <= IR_CAPTURE;
    end else if (state == ST_SHIFT_IR) begin
      ir_shift_reg <= {i_tdi, ir_shift_reg[IR_W-1:1]};
    end
  end

  // current instruction only moves at update-ir or on reset
  always_ff @(posedge i_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      instr_reg <= IR_RESET;
    end else if (state == ST_TLR) begin
      instr_reg <= IR_RESET;
    end else if (state == ST_UPD_IR) begin
      instr_reg <= ir_shift_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data registers

  // identification register reloads its fixed word at capture-dr
  always_ff @(posedge i_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      id_shift_reg <= '0;
    end else if (state == ST_CAP_DR && path == PATH_ID) begin
      id_shift_reg <= ID_VALUE;
    end else if (state == ST_SHIFT_DR && path == PATH_ID) begin
      id_shift_reg <= {i_tdi, id_shift_reg[ID_W-1:1]};
    end
  end

  // single bypass stage
  always_ff @(posedge i_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bypass_reg <= BYP_CAPTURE;
    end else if (state == ST_CAP_DR && path == PATH_BYP) begin
      bypass_reg <= BYP_CAPTURE;
    end else if (state == ST_SHIFT_DR && path == PATH_BYP) begin
      bypass_reg <= i_tdi;
    end
  end

  // observed pins come from other domains; two flops before capture
  always_ff @(posedge i_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      obs_meta_reg <= '0;
      obs_sync_reg <= '0;
    end else begin
      obs_meta_reg <= {o_pin_oe, o_pin_out, i_pin_in};
      obs_sync_reg <= obs_meta_reg;
    end
  end

  // chain covers functional pins only, never the test pins
  bst_cell_chain #(
    .N_IN(N_IN),
    .N_OUT(N_OUT)
  ) u_chain (
    .i_tck(i_tck),
    .i_tap_rst_n(tap_rst_n),
    .i_capture(state == ST_CAP_DR && path == PATH_BSR),
    .i_shift(state == ST_SHIFT_DR && path == PATH_BSR),
    .i_update(state == ST_UPD_DR && path == PATH_BSR),
    .i_tdi(i_tdi),
    .i_pin_in(obs_sync_reg[N_IN-1:0]),
    .i_pin_out(obs_sync_reg[N_IN+N_OUT-1:N_IN]),
    .i_pin_oe(obs_sync_reg[OBS_W-1:N_IN+N_OUT]),
    .o_so(bsr_so),
    .o_upd_out(upd_out),
    .o_upd_oe(upd_oe)
  );

  ////////////////////////////////////////////////////////////////////
  // pin muxing

  // highz wins; extest and clamp drive update stage; else core owns pins
  always_comb begin
    if (instr_reg == INS_HIGHZ) begin
      o_pin_out = i_core_out;
      o_pin_oe = '0;
    end else if (forces_pins(instr_reg)) begin
      o_pin_out = upd_out;
      o_pin_oe = upd_oe;
    end else begin
      o_pin_out = i_core_out;
      o_pin_oe = i_core_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // tdo

  // serial source for the current scan
  always_comb begin
    if (state == ST_SHIFT_IR) begin
      serial_bit = ir_shift_reg[0];
    end else begin
      case (path)
        PATH_BSR: serial_bit = bsr_so;
        PATH_ID: serial_bit = id_shift_reg[0];
        default: serial_bit = bypass_reg;
      endcase
    end
  end

  // falling edge gives the controller half a period of hold
  always_ff @(negedge i_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo <= serial_bit;
      o_tdo_oe <= shifting;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // core-side view of test ownership

  // registered in tck domain so only a clean level crosses
  always_ff @(posedge i_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      test_active_reg <= 1'b0;
    end else begin
      test_active_reg <= forces_pins(instr_reg) || (instr_reg == INS_HIGHZ);
    end
  end

  // two-flop synchroniser; first stage feeds nothing else
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_sync_reg <= '0;
    end else begin
      core_sync_reg <= {core_sync_reg[0], test_active_reg};
    end
  end

  assign o_core_test_active = core_sync_reg[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////
  // checks, all on the test clock

  default clocking tck_cb @(posedge i_tck);
  endclocking
  default disable iff (!tap_rst_n);

  // low until the first tck edge after any reset, so history never spans one
  logic live_reg;
  always_ff @(posedge i_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      live_reg <= 1'b0;
    end else begin
      live_reg <= 1'b1;
    end
  end

  sequence s_id_capture;
    (state == ST_CAP_DR) && (instr_reg == INS_IDCODE);
  endsequence

  sequence s_bsr_capture;
    (state == ST_CAP_DR) && (path == PATH_BSR);
  endsequence

  sequence s_bypass_shift;
    (state == ST_SHIFT_DR) && (instr_reg == INS_BYPASS) ##1 (state == ST_SHIFT_DR);
  endsequence

  chk_ir_shift_in: assert property (
    (state == ST_SHIFT_IR) |=> (ir_shift_reg[IR_W-1] == $past(i_tdi))
  ) else $error("instruction shift lost tdi");

  chk_ir_capture_pat: assert property (
    (state == ST_CAP_IR) |=> (ir_shift_reg[1:0] == 2'h1)
  ) else $error("capture-ir pattern wrong");

  chk_ir_update_only: assert property (
    live_reg && $changed(instr_reg) |-> ($past(state) == ST_UPD_IR || $past(state) == ST_TLR)
  ) else $error("instruction changed outside update");

  chk_tlr_idcode: assert property (
    (state == ST_TLR) |=> (instr_reg == INS_IDCODE)
  ) else $error("reset state not idcode");

  chk_id_first_bit: assert property (
    s_id_capture ##1 (state == ST_SHIFT_DR) |-> o_tdo
  ) else $error("id marker bit not one");

  chk_bsr_first_out: assert property (
    s_bsr_capture ##1 (state == ST_SHIFT_DR) |-> (o_tdo == $past(obs_sync_reg[0]))
  ) else $error("boundary bit 0 not first out");

  chk_bypass_one_bit: assert property (
    s_bypass_shift |-> (o_tdo == $past(i_tdi))
  ) else $error("bypass path not one stage");

  chk_tdo_float: assert property (
    o_tdo_oe == ((state == ST_SHIFT_IR) || (state == ST_SHIFT_DR))
  ) else $error("tdo driven outside shift");

  chk_highz_pins: assert property (
    (instr_reg == INS_HIGHZ) |-> (o_pin_oe == '0)
  ) else $error("pins driven under highz");

  chk_force_pins: assert property (
    forces_pins(instr_reg) |-> (o_pin_out == upd_out) && (o_pin_oe == upd_oe)
  ) else $error("pins not from update stage");

  chk_sample_pins: assert property (
    (instr_reg == INS_SAMPLE) |-> (o_pin_out == i_core_out) && (o_pin_oe == i_core_oe)
  ) else $error("sample disturbed pins");

endmodule
`default_nettype wire

// >>> tb/bst_test_ctrl.sv
// model of the external test controller driving the scan link
`timescale 1ns/100ps
`default_nettype none
module bst_test_ctrl #(
  parameter int HALF_NS = 32
) (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  // idle link: tck stands low, released lines sit at their pull-up level
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_trst_n = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // one tck period; a floating tdo reads as unknown so it never matches
  task automatic bit_cycle(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #(HALF_NS);
    o_tck = 1'b1;
    tdo = i_tdo_oe ? i_tdo : 1'bx;
    #(HALF_NS);
    o_tck = 1'b0;
  endtask

  // full ir or dr scan from run-test/idle, lsb first, back to idle
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic t;
    dout = '0;
    bit_cycle(1'b0, 1'b1, t);
    bit_cycle(1'b1, 1'b1, t);
    if (is_ir) begin
      bit_cycle(1'b1, 1'b1, t);
    end
    bit_cycle(1'b0, 1'b1, t);
    bit_cycle(1'b0, 1'b1, t);
    for (int k = 0; k < n; k++) begin
      bit_cycle(k == n - 1, din[k], t);
      dout[k] = t;
    end
    bit_cycle(1'b1, 1'b1, t);
    bit_cycle(1'b0, 1'b1, t);
    // one idle clock in run-test/idle lets registered status follow the new instruction
    bit_cycle(1'b0, 1'b1, t);
    o_tms = 1'b1;
    o_tdi = 1'b1;
  endtask

  // five tms ones walk the controller home without the reset pin
  task automatic tms_reset();
    logic t;
    for (int k = 0; k < 5; k++) begin
      bit_cycle(1'b1, 1'b1, t);
    end
  endtask

  // test reset pulse with tck standing still, 100 ns low and recovery
  task automatic trst_pulse();
    o_trst_n = 1'b0;
    #100;
    o_trst_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_bst_tap.sv
// self-checking bench for the boundary-scan tap
`timescale 1ns/100ps
`default_nettype none
module tb_bst_tap;
  import bst_pkg::*;
  localparam int N_IN = 8;
  localparam int N_OUT = 4;
  localparam int CH_W = N_IN + 2 * N_OUT;
  localparam logic [3:0] REV = 4'h6; // arbitrary value
  localparam logic [15:0] PART = 16'h1234; // arbitrary value
  localparam logic [10:0] MFR = 11'h155; // arbitrary value
  localparam logic [15:0] PAT = 16'h9c5a;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, test_active;
  logic [N_IN-1:0] pin_in = '0;
  logic [N_OUT-1:0] core_out = '0;
  logic [N_OUT-1:0] core_oe = '0;
  logic [N_OUT-1:0] pin_out, pin_oe;
  logic [31:0] d;
  int failures = 0;
  int compares = 0;

  always #50 core_clk = ~core_clk;

  bst_tap #(.N_IN(N_IN), .N_OUT(N_OUT), .ID_REV(REV), .ID_PART(PART), .ID_MFR(MFR)) bst_tap_i (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pin_in(pin_in),
    .i_core_out(core_out), .i_core_oe(core_oe), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_core_test_active(test_active));

  bst_test_ctrl bst_test_ctrl_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
    .i_tdo(tdo), .i_tdo_oe(tdo_oe));

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // loads an instruction; the old register must shift out the capture pattern
  task automatic ir_load(input logic [3:0] code);
    bst_test_ctrl_i.scan(1'b1, IR_W, {28'h0, code}, d);
    check(d[3:0], IR_CAPTURE);
  endtask

  // core flag crosses domains; bounded wait of 20 core cycles
  task automatic wait_active(input logic exp);
    int n;
    n = 0;
    while (test_active !== exp && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    check(test_active, exp);
  endtask

  // bypass path: one stage that captured zero, then the shifted bits
  task automatic check_bypass();
    bst_test_ctrl_i.scan(1'b0, 4, 32'hb, d);
    check(d[3:0], {3'b011, BYP_CAPTURE});
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_idcode();
    check(tdo_oe, 1'b0);
    bst_test_ctrl_i.scan(1'b0, ID_W, 32'h0, d);
    check(d, {REV, PART, MFR, ID_MARK});
  endtask

  task automatic t_bypass_highz();
    ir_load(INS_BYPASS);
    check_bypass();
    ir_load(INS_HIGHZ);
    wait_active(1'b1);
    check(pin_oe, '0);
    check(pin_out, core_out);
    check_bypass();
  endtask

  // preload under sample, then force the cells out with extest and clamp
  task automatic t_sample_extest();
    logic [31:0] e;
    logic [N_OUT-1:0] po, pe;
    e = '0;
    ir_load(INS_SAMPLE);
    wait_active(1'b0);
    e[N_IN-1:0] = pin_in;
    for (int j = 0; j < N_OUT; j++) begin
      e[N_IN + 2 * j] = core_out[j];
      e[N_IN + 2 * j + 1] = core_oe[j];
      po[j] = PAT[N_IN + 2 * j];
      pe[j] = PAT[N_IN + 2 * j + 1];
    end
    bst_test_ctrl_i.scan(1'b0, CH_W, {16'h0, PAT}, d);
    check(d, e);
    check(pin_out, core_out);
    check(pin_oe, core_oe);
    ir_load(INS_EXTEST);
    wait_active(1'b1);
    check(pin_out, po);
    check(pin_oe, pe);
    ir_load(INS_CLAMP);
    check(pin_out, po);
    check(pin_oe, pe);
    check_bypass();
  endtask

  // both reset routes bring back idcode; pins are checked back with the core after the reset pin only
  task automatic t_resets();
    bst_test_ctrl_i.trst_pulse();
    check(pin_out, core_out);
    check(pin_oe, core_oe);
    t_idcode();
    ir_load(INS_BYPASS);
    bst_test_ctrl_i.tms_reset();
    t_idcode();
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    pin_in <= 8'ha7;
    core_out <= 4'h9;
    core_oe <= 4'h5;
    repeat (2) @(posedge core_clk);
    #13;
    t_idcode();
    t_bypass_highz();
    t_sample_extest();
    t_resets();
    finish_test();
  end

  // hang guard, far beyond the normal run
  initial begin
    #2000000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
